//--- logic/ccr_defs.svh
// offsets, field positions, reset values and timing counts of the charger configuration bank
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ************************************************************
// register offsets and reset values
// ************************************************************
`define CCR_OFS_END_TOPOFF    8'h1A
`define CCR_OFS_THERM_VSYS    8'h1B
`define CCR_OFS_FCC_TIMER     8'h1C
`define CCR_RST_END_TOPOFF    8'hF8
`define CCR_RST_THERM_VSYS    8'h10
`define CCR_RST_FCC_TIMER     8'h05
`define CCR_NUM_REGS          2'h3

// ************************************************************
// field positions
// ************************************************************
`define CCR_PQ_MSB            7
`define CCR_PQ_LSB            5
`define CCR_TERM_MSB          4
`define CCR_TERM_LSB          3
`define CCR_TOPOFF_MSB        2
`define CCR_TOPOFF_LSB        0
`define CCR_TJ_MSB            7
`define CCR_TJ_LSB            5
`define CCR_VSYS_MSB          4
`define CCR_VSYS_LSB          0
`define CCR_FCC_MSB           7
`define CCR_FCC_LSB           2
`define CCR_TMR_MSB           1
`define CCR_TMR_LSB           0

// ************************************************************
// decode constants: voltages in mV, currents in uA, times in minutes
// ************************************************************
`define CCR_VSYS_BASE_MV      13'h1004
`define CCR_VSYS_STEP_MV      13'h0019
`define CCR_VSYS_SAT_CODE     5'h1C
`define CCR_VSYS_MAX_MV       13'h12C0
`define CCR_FCC_STEP_UA       19'h01D4C
`define CCR_FCC_SAT_CODE      6'h27
`define CCR_FCC_MAX_UA        19'h493E0
`define CCR_TOPOFF_STEP_MIN   6'h05
`define CCR_TMR_3H_MIN        10'h0B4
`define CCR_TMR_5H_MIN        10'h12C
`define CCR_TMR_7H_MIN        10'h1A4
`define CCR_TERM_5_PERMIL     8'h32
`define CCR_TERM_7P5_PERMIL   8'h4B
`define CCR_TERM_10_PERMIL    8'h64
`define CCR_TERM_15_PERMIL    8'h96

`endif

//--- logic/ccr_pkg.sv
// types shared by the charger configuration bank
package ccr_pkg;

    // one register access on the documented serial register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_req_t;

    // decoded settings presented to the charger
    typedef struct packed {
        logic [2:0]  prequal_voltage_sel;
        logic [7:0]  term_permil;
        logic [5:0]  topoff_min;
        logic [2:0]  junction_temp_regulation_sel;
        logic [12:0] system_voltage_target_mv;
        logic [18:0] fast_charge_current_ua;
        logic        safety_timer_en;
        logic [9:0]  safety_timer_min;
    } ccr_cfg_t;

    typedef enum logic [1:0] {
        CCR_SEL_END_TOPOFF = 2'h0,
        CCR_SEL_THERM_VSYS = 2'h1,
        CCR_SEL_FCC_TIMER  = 2'h2
    } ccr_sel_t;

endpackage

//--- logic/ccr_reg_word.sv
// one 8-bit configuration register with its own reset value
`timescale 1ns/1ps
module ccr_reg_word #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       system_reset_event,
    // write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // stored value
    output logic [7:0]      q
);

    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    // system reset reloads the default and wins over a write
    always_comb begin
        nxt_q = q_ff;
        if (system_reset_event) begin
            nxt_q = RESET_VAL;
        end else if (wr_en) begin
            nxt_q = wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q_ff <= RESET_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;

endmodule

//--- logic/ccr_config_bank.sv
// charger configuration bank: three read/write registers and their decoded settings
`timescale 1ns/1ps
`include "ccr_defs.svh"

// Functional notes
// - termination code 00,01,10,11 selects 5, 7.5, 10, 15 percent
// - junction temperature field in top bits; 000 is 60C, 001 is 70C
// - system voltage code zero is 4.1V, each code adds 25mV
// - system voltage codes 0x1C and above saturate at 4.800V
// - fast-charge current field selects 7.5mA to 300mA in 7.5mA steps
// - safety timer code 00 disables the fast-charge safety timer
// - safety timer codes 01,10,11 select 3, 5, 7 hours
module ccr_config_bank (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             system_reset_event,
    // register port
    input  ccr_pkg::ccr_req_t     req,
    output logic [7:0]            rdata,
    output logic                  rvalid,
    output logic                  addr_hit,
    // decoded settings
    output ccr_pkg::ccr_cfg_t     cfg
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0]         rdata;
        logic               rvalid;
        ccr_pkg::ccr_cfg_t  cfg;
    } ccr_state_t;

    ccr_state_t st_ff;
    ccr_state_t nxt_st;

    logic [7:0]  regs [3];
    logic [2:0]  wr_sel;
    logic        hit;
    logic [1:0]  sel_idx;

    // ************************************************************
    // address decode
    // ************************************************************
    always_comb begin
        hit     = 1'b1;
        sel_idx = ccr_pkg::CCR_SEL_END_TOPOFF;
        unique case (req.addr)
            `CCR_OFS_END_TOPOFF: sel_idx = ccr_pkg::CCR_SEL_END_TOPOFF;
            `CCR_OFS_THERM_VSYS: sel_idx = ccr_pkg::CCR_SEL_THERM_VSYS;
            `CCR_OFS_FCC_TIMER:  sel_idx = ccr_pkg::CCR_SEL_FCC_TIMER;
            default:             hit = 1'b0;   // other charger registers live elsewhere
        endcase
    end

    assign addr_hit = hit;

    // ************************************************************
    // register words, one per offset
    // ************************************************************
    localparam logic [7:0] RST_VALS [3] = '{`CCR_RST_END_TOPOFF,
                                            `CCR_RST_THERM_VSYS,
                                            `CCR_RST_FCC_TIMER};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_reg
            assign wr_sel[gi] = req.wr && hit && (sel_idx == 2'(gi));
            ccr_reg_word #(
                .RESET_VAL (RST_VALS[gi])
            ) u_word (
                .ref_clk            (ref_clk),
                .resetn             (resetn),
                .system_reset_event (system_reset_event),
                .wr_en              (wr_sel[gi]),
                .wdata              (req.wdata),
                .q                  (regs[gi])
            );
        end
    endgenerate

    // ************************************************************
    // next state: read data and decoded fields
    // ************************************************************
    logic [2:0] tof;
    logic [1:0] term;
    logic [4:0] vsys;
    logic [5:0] fcc;
    logic [1:0] tmr;

    assign tof  = regs[0][`CCR_TOPOFF_MSB:`CCR_TOPOFF_LSB];
    assign term = regs[0][`CCR_TERM_MSB:`CCR_TERM_LSB];
    assign vsys = regs[1][`CCR_VSYS_MSB:`CCR_VSYS_LSB];
    assign fcc  = regs[2][`CCR_FCC_MSB:`CCR_FCC_LSB];
    assign tmr  = regs[2][`CCR_TMR_MSB:`CCR_TMR_LSB];

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = req.rd;
        // unmapped reads return zero; reads see the stored word
        if (req.rd) begin
            nxt_st.rdata = hit ? regs[sel_idx] : 8'h00;
        end
        nxt_st.cfg.prequal_voltage_sel = regs[0][`CCR_PQ_MSB:`CCR_PQ_LSB];
        // termination in tenths of a percent so 7.5 stays exact
        unique case (term)
            2'h0: nxt_st.cfg.term_permil = 8'(`CCR_TERM_5_PERMIL);
            2'h1: nxt_st.cfg.term_permil = 8'(`CCR_TERM_7P5_PERMIL);
            2'h2: nxt_st.cfg.term_permil = 8'(`CCR_TERM_10_PERMIL);
            2'h3: nxt_st.cfg.term_permil = 8'(`CCR_TERM_15_PERMIL);
        endcase
        nxt_st.cfg.topoff_min = 6'(tof * `CCR_TOPOFF_STEP_MIN);
        nxt_st.cfg.junction_temp_regulation_sel =
            regs[1][`CCR_TJ_MSB:`CCR_TJ_LSB];
        // linear step, clamped at the ceiling code
        if (vsys >= `CCR_VSYS_SAT_CODE) begin
            nxt_st.cfg.system_voltage_target_mv = `CCR_VSYS_MAX_MV;
        end else begin
            nxt_st.cfg.system_voltage_target_mv =
                13'(`CCR_VSYS_BASE_MV + 13'(vsys) * `CCR_VSYS_STEP_MV);
        end
        // code n gives (n+1) steps of 7.5mA, flat at the ceiling so no code overdrives
        if (fcc >= `CCR_FCC_SAT_CODE) begin
            nxt_st.cfg.fast_charge_current_ua = `CCR_FCC_MAX_UA;
        end else begin
            nxt_st.cfg.fast_charge_current_ua =
                19'((19'(fcc) + 19'h00001) * `CCR_FCC_STEP_UA);
        end
        nxt_st.cfg.safety_timer_en = (tmr != 2'h0);
        unique case (tmr)
            2'h0: nxt_st.cfg.safety_timer_min = 10'h000;
            2'h1: nxt_st.cfg.safety_timer_min = `CCR_TMR_3H_MIN;
            2'h2: nxt_st.cfg.safety_timer_min = `CCR_TMR_5H_MIN;
            2'h3: nxt_st.cfg.safety_timer_min = `CCR_TMR_7H_MIN;
        endcase
    end

    // ************************************************************
    // state register; decoded values follow the words one cycle later
    // ************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata  = st_ff.rdata;
    assign rvalid = st_ff.rvalid;
    assign cfg    = st_ff.cfg;

    // ************************************************************
    // checks
    // ************************************************************
    // each cfg property waits one edge because cfg is registered from the words
    // readback: write, one quiet cycle, then a read of the same offset
    a_write_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
        (req.wr && hit && !system_reset_event) ##1 (!req.wr && !system_reset_event)
        ##1 (req.rd && req.addr == $past(req.addr, 2)) |=> (rdata == $past(req.wdata, 3)))
        else $error("read does not return written value");
    a_system_reset_event_reload: assert property (@(posedge ref_clk) disable iff (!resetn)
        system_reset_event |=> (regs[0] == `CCR_RST_END_TOPOFF
        && regs[1] == `CCR_RST_THERM_VSYS && regs[2] == `CCR_RST_FCC_TIMER))
        else $error("defaults not reloaded on system reset");
    a_vsys_sat: assert property (@(posedge ref_clk) disable iff (!resetn)
        (vsys >= 5'h1C) |=> (cfg.system_voltage_target_mv == 13'h12C0))
        else $error("system voltage not saturated");
    a_vsys_lin: assert property (@(posedge ref_clk) disable iff (!resetn)
        (vsys < 5'h1C) |=> (cfg.system_voltage_target_mv ==
        13'(13'd4100 + 13'($past(vsys)) * 13'd25)))
        else $error("system voltage step wrong");
    a_timer_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tmr == 2'h0) |=> (!cfg.safety_timer_en && cfg.safety_timer_min == 10'h000))
        else $error("safety timer not disabled");
    a_timer_hours: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tmr == 2'h3) |=> (cfg.safety_timer_en && cfg.safety_timer_min == 10'd420))
        else $error("safety timer duration wrong");
    a_fcc_top: assert property (@(posedge ref_clk) disable iff (!resetn)
        (fcc == 6'h27) |=> (cfg.fast_charge_current_ua == 19'd300000))
        else $error("fast charge current wrong");
    a_term_pct: assert property (@(posedge ref_clk) disable iff (!resetn)
        (term == 2'h1) |=> (cfg.term_permil == 8'd75))
        else $error("termination percent wrong");
    a_topoff_min: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tof == 3'h7) |=> (cfg.topoff_min == 6'd35))
        else $error("top-off minutes wrong");
    a_tj_field: assert property (@(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> (cfg.junction_temp_regulation_sel == $past(regs[1][7:5])))
        else $error("junction temperature field wrong");
    // field end points, middle timer codes and read framing
    a_fcc_sat: assert property (@(posedge ref_clk) disable iff (!resetn)
        (fcc > 6'h27) |=> (cfg.fast_charge_current_ua == 19'd300000))
        else $error("fast charge current not saturated");
    a_fcc_base: assert property (@(posedge ref_clk) disable iff (!resetn)
        (fcc == 6'h00) |=> (cfg.fast_charge_current_ua == 19'd7500))
        else $error("fast charge current base wrong");
    a_term_top: assert property (@(posedge ref_clk) disable iff (!resetn)
        (term == 2'h3) |=> (cfg.term_permil == 8'd150))
        else $error("termination top percent wrong");
    a_term_base: assert property (@(posedge ref_clk) disable iff (!resetn)
        (term == 2'h0) |=> (cfg.term_permil == 8'd50))
        else $error("termination base percent wrong");
    a_timer_three: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tmr == 2'h1) |=> (cfg.safety_timer_en && cfg.safety_timer_min == 10'd180))
        else $error("safety timer three hours wrong");
    a_timer_five: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tmr == 2'h2) |=> (cfg.safety_timer_en && cfg.safety_timer_min == 10'd300))
        else $error("safety timer five hours wrong");
    a_topoff_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tof == 3'h0) |=> (cfg.topoff_min == 6'd0))
        else $error("top-off zero minutes wrong");
    a_read_valid: assert property (@(posedge ref_clk) disable iff (!resetn)
        req.rd |=> rvalid)
        else $error("read not answered with valid");
    a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!resetn)
        (req.rd && !hit) |=> (rdata == 8'h00))
        else $error("unmapped read not zero");

endmodule

//--- tb/ccr_host_model.sv
// host side model of the charger bank register port
`timescale 1ns/1ps
module ccr_host_model (
    // clock
    input  wire logic         ref_clk,
    // register port
    output ccr_pkg::ccr_req_t req,
    input  wire logic [7:0]   rdata,
    input  wire logic         rvalid,
    input  wire logic         addr_hit
);
    // idle port from time zero
    initial begin
        req = '0;
    end

    // one access held to its taking edge, then one idle cycle
    task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic v, output logic h);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        #1;
        h = addr_hit;
        @(posedge ref_clk);
        #1;
        q = rdata;
        v = rvalid;
        // released lines show a changed value, never the stale one
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge ref_clk);
        #1;
    endtask
endmodule

//--- tb/tb_charger_config_registers.sv
// self-checking bench for the charger configuration bank
`timescale 1ns/1ps
module tb_charger_config_registers;
    logic              ref_clk;
    logic              resetn;
    logic              system_reset_event;
    ccr_pkg::ccr_req_t req;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              addr_hit;
    ccr_pkg::ccr_cfg_t cfg;
    int                err_total;
    int                check_count;
    int                mdl[3];
    logic [15:0]       lfsr_st;
    logic [7:0]        q;
    logic              v;
    logic              h;

    // ****
    // design and host
    // ****
    ccr_config_bank dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .system_reset_event(system_reset_event), .req(req), .rdata(rdata),
        .rvalid(rvalid), .addr_hit(addr_hit), .cfg(cfg));
    ccr_host_model host_u (.ref_clk(ref_clk), .req(req), .rdata(rdata),
        .rvalid(rvalid), .addr_hit(addr_hit));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
    end
    always #4 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // ****
    // reference model and access helpers
    // ****
    task automatic mreset();
        mdl = '{8'hF8, 8'h10, 8'h05};
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, 1'b0, a, d, q, v, h);
        check(v, 0);
        if (a >= 8'h1A && a <= 8'h1C) mdl[a - 8'h1A] = d;
    endtask

    task automatic rreg(input logic [7:0] a);
        bit hit;
        hit = a >= 8'h1A && a <= 8'h1C;
        host_u.xfer(1'b0, 1'b1, a, 8'h00, q, v, h);
        check(v, 1);
        check(h, hit);
        check(q, hit ? mdl[a - 8'h1A] : 0);
    endtask

    // read back all three words, then the decoded settings
    task automatic check_all();
        int tp[4] = '{50, 75, 100, 150};
        int tm[4] = '{0, 180, 300, 420};
        int t;
        int c;
        int f;
        int s;
        rreg(8'h1A);
        rreg(8'h1B);
        rreg(8'h1C);
        t = mdl[0];
        c = mdl[1];
        f = mdl[2];
        check(cfg.prequal_voltage_sel, t[7:5]);
        check(cfg.term_permil, tp[t[4:3]]);
        check(cfg.topoff_min, 5 * t[2:0]);
        check(cfg.junction_temp_regulation_sel, c[7:5]);
        s = (c[4:0] >= 28) ? 4800 : 4100 + 25 * c[4:0];
        check(cfg.system_voltage_target_mv, s);
        s = 7500 * (f[7:2] + 1);
        check(cfg.fast_charge_current_ua, (s > 300000) ? 300000 : s);
        check(cfg.safety_timer_en, f[1:0] != 0);
        check(cfg.safety_timer_min, tm[f[1:0]]);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        err_total = 0;
        check_count = 0;
        lfsr_st = 16'hAF9A;
        resetn = 1'b0;
        system_reset_event = 1'b0;
        mreset();
        repeat (12) @(posedge ref_clk);
        #1 resetn = 1'b1;
        check_all();
        $display("test reset defaults done");
        // every termination, top-off, system voltage and fast-charge code at least once, other fields random
        for (int i = 0; i < 64; i++) begin
            lfsr_st = lfsr_next(lfsr_st);
            wreg(8'h1A, {lfsr_st[7:5], i[1:0], i[4:2]});
            wreg(8'h1B, {lfsr_st[10:8], i[4:0]});
            wreg(8'h1C, {i[5:0], lfsr_st[1:0]});
            check_all();
        end
        $display("test field codes done");
        // read each word back one idle cycle after a random write
        for (int i = 0; i < 3; i++) begin
            lfsr_st = lfsr_next(lfsr_st);
            wreg(8'h1A + 8'(i), lfsr_st[7:0]);
            rreg(8'h1A + 8'(i));
        end
        $display("test readback done");
        wreg(8'h1D, 8'hA5);
        wreg(8'h19, 8'h5A);
        rreg(8'h1D);
        rreg(8'hFF);
        check_all();
        $display("test unmapped done");
        // a write in the same cycle as the system reset is lost
        fork
            wreg(8'h1B, 8'hFF);
            begin
                system_reset_event = 1'b1;
                @(posedge ref_clk);
                #1 system_reset_event = 1'b0;
            end
        join
        mreset();
        check_all();
        $display("test system reset done");
        wreg(8'h1A, 8'h00);
        resetn = 1'b0;
        #2;
        check(rvalid, 0);
        check(rdata, 0);
        check(cfg === '0, 1);
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        mreset();
        check_all();
        $display("test async reset done");
        results();
    end

    // hang guard, well beyond the roughly 830 cycles of the run
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule
